// *** sdc_map.svh ***
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH
// register addresses (8-bit address port)
`define SDC_ADDR_CTRL      8'h00
`define SDC_ADDR_INPUT     8'h01
`define SDC_ADDR_SEQ       8'h02
`define SDC_ADDR_STATUS    8'h03
`define SDC_ADDR_RESULT    8'h04
`define SDC_ADDR_WINDOW_CONTROL   8'h05
`define SDC_ADDR_WINLO     8'h06
`define SDC_ADDR_WINHI     8'h07
`define SDC_ADDR_FLAGS     8'h08
`define SDC_ADDR_MASK      8'h09
// field positions
`define SDC_CTRL_START_BIT 0
`define SDC_FLAG_RDY_BIT   0
`define SDC_FLAG_WIN_BIT   1
`define SDC_STAT_BUSY_BIT  0
`define SDC_STAT_POS_LSB   4
// reset values
`define SDC_RST_INPUT      2'h0
`define SDC_RST_SEQ        3'h0
`define SDC_RST_WINDOW_COMPARE_MODE    3'h0
`define SDC_RST_BOUND      16'h0000
`define SDC_RST_MASK       2'h0
`define SDC_NUM_INPUTS     3
`endif

// *** sdc_pkg.sv ***
package sdc_pkg;
  typedef enum logic [2:0] {
    WIN_OFF,
    WIN_ABOVE,
    WIN_BELOW,
    WIN_INSIDE,
    WIN_OUTSIDE
  } win_mode_e;

  typedef struct packed {
    logic        start;
    logic [1:0]  input_num;
  } conv_req_s;

  typedef struct packed {
    logic        done;
    logic [15:0] value;
  } conv_res_s;
endpackage : sdc_pkg

// *** sdc_seq_pick.sv ***
`timescale 1ns/1ps
// picks lowest selected input at or above a floor
module sdc_seq_pick (
  input  wire logic [2:0] sel_i,
  input  wire logic [1:0] floor_i,
  output logic            found_o,
  output logic [1:0]      num_o
);
  logic [2:0] hit;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_hit
      assign hit[g] = sel_i[g] && (2'(g) >= floor_i);
    end
  endgenerate
  assign found_o = |hit;
  assign num_o   = hit[0] ? 2'h0 : (hit[1] ? 2'h1 : 2'h2);
endmodule : sdc_seq_pick

// *** sdc_window.sv ***
`timescale 1ns/1ps
module sdc_window (
  input  wire logic [2:0]  mode_i,
  input  wire logic [15:0] value_i,
  input  wire logic [15:0] lower_i,
  input  wire logic [15:0] upper_i,
  output logic             hit_o
);
  sdc_pkg::win_mode_e mode;
  logic above;
  logic below;
  assign mode  = sdc_pkg::win_mode_e'(mode_i);
  assign above = value_i > lower_i;
  assign below = value_i < upper_i;
  always_comb begin
    case (mode)
      sdc_pkg::WIN_ABOVE:   hit_o = above;
      sdc_pkg::WIN_BELOW:   hit_o = below;
      sdc_pkg::WIN_INSIDE:  hit_o = above && below;
      sdc_pkg::WIN_OUTSIDE: hit_o = !(above && below);
      default:              hit_o = 1'b0;
    endcase
  end
endmodule : sdc_window

// *** sigma_delta_converter.sv ***
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "sdc_map.svh"
// Function
// - each conversion yields a 16-bit result
// - one start runs a whole sequence
// - each input has a sequence select bit
// - sequence converts inputs in ascending order
// - active flag spans sequence start to final conversion; a start with an empty selection leaves it clear
// - position holds last converted input number
// - every conversion stores result, sets ready
// - next selected input starts without request
// - empty selection converts the input_select input
// - window mode field chooses comparison
// - window hit flag set on match
module sigma_delta_converter (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  output logic             irq_o,
  output logic             conv_start_o,
  output logic [1:0]       conv_input_o,
  input  wire logic        conv_done_i,
  input  wire logic [15:0] conv_data_i
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_WAIT
  } state_e;

  state_e      state_reg, state_next;
  logic [1:0]  input_sel_reg;
  logic [2:0]  seq_sel_reg;
  logic [2:0]  window_compare_mode_reg;
  logic [15:0] win_lo_reg;
  logic [15:0] win_hi_reg;
  logic [15:0] result_reg;
  logic [1:0]  flags_reg, flags_next;
  logic [1:0]  mask_reg;
  logic        active_reg;
  logic [1:0]  position_reg;
  logic [1:0]  cur_reg, cur_next;
  logic        seq_mode_reg;
  logic [31:0] rdata_reg;
  logic        irq_reg;
  logic        start_reg;

  sdc_pkg::conv_res_s res;
  assign res = '{done: conv_done_i && (state_reg == ST_WAIT), value: conv_data_i};

  // start and input leave together so the front end never sees a mixed pair
  sdc_pkg::conv_req_s req;
  assign req = '{start: start_reg, input_num: cur_reg};

  // write decode
  wire wr_ctrl    = wr_i && (addr_i == `SDC_ADDR_CTRL);
  wire wr_input   = wr_i && (addr_i == `SDC_ADDR_INPUT);
  wire wr_seq     = wr_i && (addr_i == `SDC_ADDR_SEQ);
  wire wr_window_control = wr_i && (addr_i == `SDC_ADDR_WINDOW_CONTROL);
  wire wr_winlo   = wr_i && (addr_i == `SDC_ADDR_WINLO);
  wire wr_winhi   = wr_i && (addr_i == `SDC_ADDR_WINHI);
  wire wr_flags   = wr_i && (addr_i == `SDC_ADDR_FLAGS);
  wire wr_mask    = wr_i && (addr_i == `SDC_ADDR_MASK);
  // irq follows a mask write in the same cycle instead of lagging by one
  wire [1:0] mask_next = wr_mask ? wdata_i[1:0] : mask_reg;
  // a start while busy is ignored so a running sequence is never cut short
  wire start_req  = wr_ctrl && wdata_i[`SDC_CTRL_START_BIT] && (state_reg == ST_IDLE);

  // next input search
  logic       first_found;
  logic [1:0] first_num;
  logic       next_found;
  logic [1:0] next_num;
  wire  [1:0] next_floor = (cur_reg == 2'h2) ? 2'h3 : cur_reg + 2'h1;

  sdc_seq_pick u_first (
    .sel_i   (seq_sel_reg),
    .floor_i (2'h0),
    .found_o (first_found),
    .num_o   (first_num)
  );

  // floor 3 yields no hit, ending the sequence after the top input
  sdc_seq_pick u_next (
    .sel_i   (seq_sel_reg),
    .floor_i (next_floor),
    .found_o (next_found),
    .num_o   (next_num)
  );

  logic win_hit;
  sdc_window u_win (
    .mode_i  (window_compare_mode_reg),
    .value_i (conv_data_i),
    .lower_i (win_lo_reg),
    .upper_i (win_hi_reg),
    .hit_o   (win_hit)
  );

  wire more = seq_mode_reg && next_found;

  always_comb begin
    state_next = state_reg;
    cur_next   = cur_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_req) begin
          state_next = ST_START;
          cur_next   = first_found ? first_num : input_sel_reg;
        end
      end
      ST_START: state_next = ST_WAIT;
      ST_WAIT: begin
        if (res.done) begin
          if (more) begin
            state_next = ST_START;
            cur_next   = next_num;
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // set wins over write-one clear
  always_comb begin
    flags_next = flags_reg & ~(wr_flags ? wdata_i[1:0] : 2'h0);
    if (res.done) begin
      flags_next[`SDC_FLAG_RDY_BIT] = 1'b1;
      if (win_hit) begin
        flags_next[`SDC_FLAG_WIN_BIT] = 1'b1;
      end
    end
  end

  // read mux
  logic [31:0] rd_mux;
  always_comb begin
    case (addr_i)
      `SDC_ADDR_INPUT:   rd_mux = {30'h0, input_sel_reg};
      `SDC_ADDR_SEQ:     rd_mux = {29'h0, seq_sel_reg};
      `SDC_ADDR_STATUS:  rd_mux = {26'h0, position_reg, 3'h0, active_reg};
      `SDC_ADDR_RESULT:  rd_mux = {16'h0, result_reg};
      `SDC_ADDR_WINDOW_CONTROL: rd_mux = {29'h0, window_compare_mode_reg};
      `SDC_ADDR_WINLO:   rd_mux = {16'h0, win_lo_reg};
      `SDC_ADDR_WINHI:   rd_mux = {16'h0, win_hi_reg};
      `SDC_ADDR_FLAGS:   rd_mux = {30'h0, flags_reg};
      `SDC_ADDR_MASK:    rd_mux = {30'h0, mask_reg};
      default:           rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg     <= ST_IDLE;
      cur_reg       <= 2'h0;
      seq_mode_reg  <= 1'b0;
      active_reg    <= 1'b0;
      position_reg  <= 2'h0;
      result_reg    <= 16'h0000;
      flags_reg     <= 2'h0;
      start_reg     <= 1'b0;
    end else begin
      state_reg <= state_next;
      cur_reg   <= cur_next;
      flags_reg <= flags_next;
      start_reg <= (state_next == ST_START);
      if (start_req) begin
        seq_mode_reg <= first_found;
        active_reg   <= first_found;
      end else if (res.done && !more) begin
        active_reg <= 1'b0;
      end
      if (res.done) begin
        result_reg   <= res.value;
        position_reg <= cur_reg;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      input_sel_reg <= `SDC_RST_INPUT;
      seq_sel_reg   <= `SDC_RST_SEQ;
      window_compare_mode_reg   <= `SDC_RST_WINDOW_COMPARE_MODE;
      win_lo_reg    <= `SDC_RST_BOUND;
      win_hi_reg    <= `SDC_RST_BOUND;
      mask_reg      <= `SDC_RST_MASK;
      rdata_reg     <= 32'h0;
      irq_reg       <= 1'b0;
    end else begin
      if (wr_input && wdata_i[1:0] < 2'(`SDC_NUM_INPUTS)) input_sel_reg <= wdata_i[1:0];
      if (wr_seq) seq_sel_reg <= wdata_i[2:0];
      if (wr_window_control) window_compare_mode_reg <= wdata_i[2:0];
      if (wr_winlo) win_lo_reg <= wdata_i[15:0];
      if (wr_winhi) win_hi_reg <= wdata_i[15:0];
      if (wr_mask) mask_reg <= wdata_i[1:0];
      rdata_reg <= rd_i ? rd_mux : 32'h0;
      irq_reg   <= |(flags_next & mask_next);
    end
  end

  assign rdata_o      = rdata_reg;
  assign irq_o        = irq_reg;
  assign conv_start_o = req.start;
  assign conv_input_o = req.input_num;

  property p_ready_on_done;
    @(posedge clk_i) disable iff (!rst_n_i)
      res.done |=> flags_reg[`SDC_FLAG_RDY_BIT] && result_reg == $past(conv_data_i);
  endproperty
  a_ready_on_done: assert property (p_ready_on_done) else $error("ready flag or result missing");

  property p_position;
    @(posedge clk_i) disable iff (!rst_n_i)
      res.done |=> position_reg == $past(cur_reg);
  endproperty
  a_position: assert property (p_position) else $error("position not recorded");

  property p_active_clear;
    @(posedge clk_i) disable iff (!rst_n_i)
      (res.done && !more) |=> !active_reg && state_reg == ST_IDLE;
  endproperty
  a_active_clear: assert property (p_active_clear) else $error("active not cleared at end");

  property p_auto_next;
    @(posedge clk_i) disable iff (!rst_n_i)
      (res.done && more) |=> state_reg == ST_START && conv_start_o && conv_input_o > $past(cur_reg);
  endproperty
  a_auto_next: assert property (p_auto_next) else $error("next input not started upward");

  property p_single;
    @(posedge clk_i) disable iff (!rst_n_i)
      (start_req && seq_sel_reg == 3'h0) |=> cur_reg == $past(input_sel_reg) && !active_reg;
  endproperty
  a_single: assert property (p_single) else $error("single input not used");

  property p_first_low;
    @(posedge clk_i) disable iff (!rst_n_i)
      (start_req && seq_sel_reg[0]) |=> cur_reg == 2'h0 && active_reg;
  endproperty
  a_first_low: assert property (p_first_low) else $error("sequence not from lowest");

  property p_win_off;
    @(posedge clk_i) disable iff (!rst_n_i)
      (window_compare_mode_reg == 3'h0 && !flags_reg[`SDC_FLAG_WIN_BIT]) |=> !flags_reg[`SDC_FLAG_WIN_BIT];
  endproperty
  a_win_off: assert property (p_win_off) else $error("window flag set while off");

  property p_sticky;
    @(posedge clk_i) disable iff (!rst_n_i)
      (flags_reg[`SDC_FLAG_RDY_BIT] && !wr_flags) |=> flags_reg[`SDC_FLAG_RDY_BIT];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without clear");

  property p_win_set;
    @(posedge clk_i) disable iff (!rst_n_i)
      (res.done && win_hit) |=> flags_reg[`SDC_FLAG_WIN_BIT];
  endproperty
  a_win_set: assert property (p_win_set) else $error("window hit not flagged");

  property p_win_sticky;
    @(posedge clk_i) disable iff (!rst_n_i)
      (flags_reg[`SDC_FLAG_WIN_BIT] && !wr_flags) |=> flags_reg[`SDC_FLAG_WIN_BIT];
  endproperty
  a_win_sticky: assert property (p_win_sticky) else $error("window flag lost without clear");

  property p_clear_ready;
    @(posedge clk_i) disable iff (!rst_n_i)
      (wr_flags && wdata_i[`SDC_FLAG_RDY_BIT] && !res.done) |=> !flags_reg[`SDC_FLAG_RDY_BIT];
  endproperty
  a_clear_ready: assert property (p_clear_ready) else $error("ready flag not cleared");

  property p_clear_win;
    @(posedge clk_i) disable iff (!rst_n_i)
      (wr_flags && wdata_i[`SDC_FLAG_WIN_BIT] && !res.done) |=> !flags_reg[`SDC_FLAG_WIN_BIT];
  endproperty
  a_clear_win: assert property (p_clear_win) else $error("window flag not cleared");

  property p_ready_only_done;
    @(posedge clk_i) disable iff (!rst_n_i)
      (!res.done && !flags_reg[`SDC_FLAG_RDY_BIT]) |=> !flags_reg[`SDC_FLAG_RDY_BIT];
  endproperty
  a_ready_only_done: assert property (p_ready_only_done) else $error("ready flag set without conversion");

  property p_result_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
      !res.done |=> $stable(result_reg);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result changed without conversion");

  property p_start_pulse;
    @(posedge clk_i) disable iff (!rst_n_i)
      conv_start_o |=> !conv_start_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse longer than one cycle");

  property p_input_stable;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_reg == ST_WAIT && !res.done) |=> $stable(conv_input_o);
  endproperty
  a_input_stable: assert property (p_input_stable) else $error("input moved during conversion");

  property p_active_set;
    @(posedge clk_i) disable iff (!rst_n_i)
      (start_req && seq_sel_reg != 3'h0) |=> active_reg;
  endproperty
  a_active_set: assert property (p_active_set) else $error("active not set at sequence start");

  property p_active_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
      (active_reg && !(res.done && !more)) |=> active_reg;
  endproperty
  a_active_hold: assert property (p_active_hold) else $error("active dropped inside sequence");

  property p_win_off_high;
    @(posedge clk_i) disable iff (!rst_n_i)
      (window_compare_mode_reg > 3'h4 && !flags_reg[`SDC_FLAG_WIN_BIT]) |=> !flags_reg[`SDC_FLAG_WIN_BIT];
  endproperty
  a_win_off_high: assert property (p_win_off_high) else $error("window flag set in unused mode");

  property p_idle_quiet;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_reg == ST_IDLE && !start_req) |=> !conv_start_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("conversion started without request");

  property p_irq_level;
    @(posedge clk_i) disable iff (!rst_n_i)
      irq_o == (|(flags_reg & mask_reg));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  property p_input_range;
    @(posedge clk_i) disable iff (!rst_n_i)
      conv_start_o |-> conv_input_o != 2'h3;
  endproperty
  a_input_range: assert property (p_input_range) else $error("conversion on missing input");
endmodule : sigma_delta_converter

// *** sdc_front_model.sv ***
`timescale 1ns/1ps
module sdc_front_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        start_i,
  input  wire logic [3:0]  delay_i,
  output logic             done_o,
  output logic [15:0]      data_o
);
  logic [4:0] cnt_reg;
  wire        finish = !start_i && (cnt_reg == 5'h01);
  // the data bus is only valid with done; elsewhere it flips so a stale sample is caught
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 5'h00;
      done_o  <= 1'b0;
      data_o  <= 16'h0000;
    end else begin
      done_o <= finish;
      data_o <= finish ? 16'($urandom) : ~data_o;
      if (start_i) begin
        cnt_reg <= {1'b0, delay_i} + 5'h01;
      end else if (cnt_reg != 5'h00) begin
        cnt_reg <= cnt_reg - 5'h01;
      end
    end
  end
endmodule : sdc_front_model

// *** tb.sv ***
`timescale 1ns/1ps
`include "sdc_map.svh"
module tb;
  logic        clk_i   = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  addr_i  = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i    = 1'b0;
  logic        rd_i    = 1'b0;
  logic [3:0]  delay   = 4'h2;
  logic [31:0] rdata_o, d;
  logic        irq_o, conv_start_o, conv_done_i;
  logic [1:0]  conv_input_o;
  logic [15:0] conv_data_i, last_data, lo, hi;
  int          n_errors = 0;
  int          n_checks = 0;
  int          n_done, cnt, s, m, e;
  int          exp_q[$];
  always #2.5 clk_i = ~clk_i;
  sigma_delta_converter dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .conv_start_o(conv_start_o), .conv_input_o(conv_input_o),
    .conv_done_i(conv_done_i), .conv_data_i(conv_data_i));
  sdc_front_model fe (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(conv_start_o), .delay_i(delay),
    .done_o(conv_done_i), .data_o(conv_data_i));

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  task automatic rc(input logic [7:0] a, input string nm, input logic [31:0] ex);
    rd(a);
    chk(nm, ex, d);
  endtask : rc
  // one start request; the monitor pops the expected inputs in order
  task automatic run(input int n, input logic act);
    delay  <= 4'(2 + $urandom % 6);
    n_done = 0;
    wr(`SDC_ADDR_CTRL, 32'h1);
    rd(`SDC_ADDR_STATUS);
    chk("active", 32'(act), 32'(d[0]));
    for (cnt = 0; cnt < 200 && n_done < n; cnt++) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
    chk("done count", n, n_done);
    chk("left inputs", 0, exp_q.size());
  endtask : run
  function automatic int win(int md, int v, int l, int h);
    case (md)
      1: return v > l;
      2: return v < h;
      3: return v > l && v < h;
      4: return !(v > l && v < h);
      default: return 0;
    endcase
  endfunction : win
  task report_and_stop;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  always @(posedge clk_i) begin
    if (rst_n_i && conv_start_o) begin
      chk("conv input", exp_q.size() ? exp_q[0] : 9, 32'(conv_input_o));
      if (exp_q.size()) void'(exp_q.pop_front());
    end
    if (rst_n_i && conv_done_i) begin
      last_data = conv_data_i;
      n_done++;
    end
  end
  initial begin
    #100000;
    n_errors++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'h59b14254));
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rc(`SDC_ADDR_STATUS, "status reset", 0);
    rc(`SDC_ADDR_FLAGS, "flags reset", 0);
    rc(8'h0f, "unmapped", 0);
    wr(`SDC_ADDR_MASK, 32'h1);
    // the last pass writes 3, which must leave input 2 selected
    for (s = 0; s < 4; s++) begin
      wr(`SDC_ADDR_INPUT, 32'(s));
      exp_q.push_back(s < 3 ? s : 2);
      run(1, 1'b0);
      rc(`SDC_ADDR_STATUS, "single status", (s < 3 ? s : 2) << 4);
      rc(`SDC_ADDR_RESULT, "result", {16'h0, last_data});
      chk("irq", 1, 32'(irq_o));
      wr(`SDC_ADDR_FLAGS, 32'h0);
      rc(`SDC_ADDR_FLAGS, "flags kept", 1);
      wr(`SDC_ADDR_FLAGS, 32'h1);
      rc(`SDC_ADDR_FLAGS, "flags cleared", 0);
      chk("irq cleared", 0, 32'(irq_o));
    end
    for (s = 1; s < 8; s++) begin
      wr(`SDC_ADDR_SEQ, 32'(s));
      for (m = 0; m < 3; m++) if (s[m]) begin
        exp_q.push_back(m);
        e = m;
      end
      run($countones(s), 1'b1);
      rc(`SDC_ADDR_STATUS, "seq status", e << 4);
      rc(`SDC_ADDR_RESULT, "seq result", {16'h0, last_data});
      rc(`SDC_ADDR_FLAGS, "seq flags", 1);
      wr(`SDC_ADDR_FLAGS, 32'h3);
    end
    wr(`SDC_ADDR_SEQ, 32'h0);
    wr(`SDC_ADDR_MASK, 32'h2);
    for (m = 0; m < 8; m++) for (s = 0; s < 6; s++) begin
      lo = 16'($urandom);
      hi = 16'($urandom);
      wr(`SDC_ADDR_WINDOW_CONTROL, 32'(m));
      wr(`SDC_ADDR_WINLO, {16'h0, lo});
      wr(`SDC_ADDR_WINHI, {16'h0, hi});
      rc(`SDC_ADDR_WINLO, "lower bound", {16'h0, lo});
      exp_q.push_back(2);
      run(1, 1'b0);
      e = win(m, last_data, lo, hi);
      rc(`SDC_ADDR_FLAGS, "window flags", (e << 1) | 1);
      chk("irq window", e, 32'(irq_o));
      wr(`SDC_ADDR_FLAGS, 32'h3);
    end
    report_and_stop;
  end
endmodule : tb
